//--- core/ccs_clock_mode_select.sv
// Core clock generation mode selector: latch, decode and clock synthesis
// Functional notes
// - Both core clock edges mark operations
// - Edge-to-edge interval is the half-cycle unit
// - Mechanism chosen by latch bits 7 to 5
// - Long reset loads latch from upper pins
// - Software reloads latch from control upper half
// - Decode eight codes into factors per table
// - Code 001 halves oscillator, phase one period
// - Multiplying codes enable loop, core equals factor
// - Resync every factor (rounded up) transitions, frequency changes smoothly
// - Code 011 disables loop, core follows oscillator
`default_nettype none

module ccs_clock_mode_select (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // Oscillator and configuration inputs
  input  wire logic                     oscillator_clock,
  input  wire logic                     long_hw_reset,
  input  wire logic [7:0]               port0_upper_pins,
  input  wire logic [15:0]              reset_control_reg,
  input  wire logic                     sw_reload,
  // Configuration state
  output logic [7:0]                    reset_config_latch,
  output logic [2:0]                    clock_gen_select,
  output logic                          pll_enable,
  // Core clock
  output logic                          core_clock,
  output logic                          core_edge,
  output logic [ccs_pkg::PER_W-1:0]     half_cycle_time
);

  // ----------------------------------------------------------------
  // Oscillator measurement
  // ----------------------------------------------------------------
  logic                      osc_level;
  logic                      osc_rise;
  logic                      osc_fall;
  logic [ccs_pkg::PER_W-1:0] osc_period;

  ccs_osc_meter u_meter (
    .clk              (clk),
    .rst_n            (rst_n),
    .oscillator_clock (oscillator_clock),
    .osc_level_ff     (osc_level),
    .osc_rise_ff      (osc_rise),
    .osc_fall_ff      (osc_fall),
    .osc_period_ff    (osc_period)
  );

  // ----------------------------------------------------------------
  // Reset configuration latch and mode
  // ----------------------------------------------------------------
  logic [7:0]          rcl_ff;
  logic [7:0]          nxt_rcl;
  ccs_pkg::ccs_mode_t  mode_ff;
  ccs_pkg::ccs_mode_t  nxt_mode;
  logic [3:0]          f2_ff;
  logic [3:0]          nxt_f2;
  logic [3:0]          rs_target_ff;
  logic [3:0]          nxt_rs_target;

  always_comb begin
    nxt_rcl = rcl_ff;
    if (long_hw_reset) begin
      nxt_rcl = port0_upper_pins;
    end else if (sw_reload) begin
      nxt_rcl = reset_control_reg[ccs_pkg::RCR_UPPER_MSB:ccs_pkg::RCR_UPPER_LSB];
    end
    nxt_mode      = ccs_pkg::ccs_decode_mode(rcl_ff[ccs_pkg::SEL_MSB:ccs_pkg::SEL_LSB]);
    nxt_f2        = ccs_pkg::ccs_twice_factor(rcl_ff[ccs_pkg::SEL_MSB:ccs_pkg::SEL_LSB]);
    nxt_rs_target = ccs_pkg::ccs_resync_count(rcl_ff[ccs_pkg::SEL_MSB:ccs_pkg::SEL_LSB]);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rcl_ff       <= ccs_pkg::RCL_RESET;
      mode_ff      <= ccs_pkg::ccs_decode_mode(ccs_pkg::RCL_RESET[ccs_pkg::SEL_MSB:ccs_pkg::SEL_LSB]);
      f2_ff        <= ccs_pkg::ccs_twice_factor(ccs_pkg::RCL_RESET[ccs_pkg::SEL_MSB:ccs_pkg::SEL_LSB]);
      rs_target_ff <= ccs_pkg::ccs_resync_count(ccs_pkg::RCL_RESET[ccs_pkg::SEL_MSB:ccs_pkg::SEL_LSB]);
    end else begin
      rcl_ff       <= nxt_rcl;
      mode_ff      <= nxt_mode;
      f2_ff        <= nxt_f2;
      rs_target_ff <= nxt_rs_target;
    end
  end

  assign reset_config_latch = rcl_ff;
  assign clock_gen_select   = rcl_ff[ccs_pkg::SEL_MSB:ccs_pkg::SEL_LSB];
  assign pll_enable         = (mode_ff == ccs_pkg::MODE_PLL);

  // ----------------------------------------------------------------
  // Core clock synthesis
  // ----------------------------------------------------------------
  logic                      core_ff;
  logic                      nxt_core;
  logic                      edge_ff;
  logic                      nxt_edge;
  logic [ccs_pkg::PER_W:0]   acc_ff;
  logic [ccs_pkg::PER_W:0]   nxt_acc;
  logic [ccs_pkg::PER_W-1:0] per_est_ff;
  logic [ccs_pkg::PER_W-1:0] nxt_per_est;
  logic [3:0]                trans_ff;
  logic [3:0]                nxt_trans;
  logic [ccs_pkg::PER_W-1:0] hc_cnt_ff;
  logic [ccs_pkg::PER_W-1:0] nxt_hc_cnt;
  logic [ccs_pkg::PER_W-1:0] hc_time_ff;
  logic [ccs_pkg::PER_W-1:0] nxt_hc_time;
  logic                      resync;

  always_comb begin
    nxt_core    = core_ff;
    nxt_acc     = acc_ff;
    nxt_per_est = per_est_ff;
    nxt_trans   = trans_ff;
    resync      = 1'b0;
    unique case (mode_ff)
      ccs_pkg::MODE_DIRECT: begin
        nxt_core = osc_level;
        nxt_acc  = '0;
      end
      ccs_pkg::MODE_PRESC: begin
        if (osc_rise) begin
          nxt_core = ~core_ff;
        end
        nxt_acc = '0;
      end
      ccs_pkg::MODE_PLL: begin
        // Phase accumulator at factor times oscillator
        if (per_est_ff != '0) begin
          nxt_acc = acc_ff + {{(ccs_pkg::PER_W - 3){1'b0}}, f2_ff};
          if (nxt_acc >= {1'b0, per_est_ff}) begin
            nxt_acc  = nxt_acc - {1'b0, per_est_ff};
            nxt_core = ~core_ff;
          end
        end
        // Gradual period correction on resync points
        if (osc_rise || osc_fall) begin
          if (trans_ff + 4'h1 >= rs_target_ff) begin
            nxt_trans = '0;
            resync    = 1'b1;
          end else begin
            nxt_trans = trans_ff + 4'h1;
          end
        end
        if (resync) begin
          if (per_est_ff == '0) begin
            nxt_per_est = osc_period;
          end else if (osc_period > per_est_ff) begin
            nxt_per_est = per_est_ff + 1'b1;
          end else if (osc_period < per_est_ff) begin
            nxt_per_est = per_est_ff - 1'b1;
          end
        end
      end
    endcase
    // Either core edge raises the marker
    nxt_edge    = nxt_core ^ core_ff;
    nxt_hc_time = hc_time_ff;
    nxt_hc_cnt  = (&hc_cnt_ff) ? hc_cnt_ff : hc_cnt_ff + 1'b1;
    if (nxt_edge) begin
      nxt_hc_time = nxt_hc_cnt;
      nxt_hc_cnt  = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      core_ff    <= 1'b0;
      edge_ff    <= 1'b0;
      acc_ff     <= '0;
      per_est_ff <= '0;
      trans_ff   <= '0;
      hc_cnt_ff  <= '0;
      hc_time_ff <= '0;
    end else begin
      core_ff    <= nxt_core;
      edge_ff    <= nxt_edge;
      acc_ff     <= nxt_acc;
      per_est_ff <= nxt_per_est;
      trans_ff   <= nxt_trans;
      hc_cnt_ff  <= nxt_hc_cnt;
      hc_time_ff <= nxt_hc_time;
    end
  end

  assign core_clock      = core_ff;
  assign core_edge       = edge_ff;
  assign half_cycle_time = hc_time_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_long_load;
    long_hw_reset |=> (rcl_ff == $past(port0_upper_pins));
  endproperty
  a_long_load: assert property (p_long_load) else $error("latch not loaded from pins");

  property p_sw_load;
    (sw_reload && !long_hw_reset) |=> (rcl_ff == $past(reset_control_reg[15:8]));
  endproperty
  a_sw_load: assert property (p_sw_load) else $error("latch not reloaded by software");

  property p_mode_follow;
    (clock_gen_select == 3'h1) |=> (mode_ff == ccs_pkg::MODE_PRESC);
  endproperty
  a_mode_follow: assert property (p_mode_follow) else $error("code 001 not prescaler");

  property p_factor;
    (clock_gen_select == 3'h0) |=> (f2_ff == 4'h5);
  endproperty
  a_factor: assert property (p_factor) else $error("code 000 factor wrong");

  property p_presc_toggle;
    (mode_ff == ccs_pkg::MODE_PRESC && $past(mode_ff) == ccs_pkg::MODE_PRESC)
      |-> ($changed(core_ff) == $past(osc_rise));
  endproperty
  a_presc_toggle: assert property (p_presc_toggle) else $error("prescaler toggle wrong");

  property p_direct;
    (mode_ff == ccs_pkg::MODE_DIRECT) ##1 (mode_ff == ccs_pkg::MODE_DIRECT) |-> (core_ff == $past(osc_level));
  endproperty
  a_direct: assert property (p_direct) else $error("direct drive not following");

  property p_pll_on;
    (clock_gen_select == 3'h7) |=> pll_enable;
  endproperty
  a_pll_on: assert property (p_pll_on) else $error("loop not enabled");

  property p_smooth;
    (mode_ff == ccs_pkg::MODE_PLL && per_est_ff != '0)
      |=> (per_est_ff <= $past(per_est_ff) + 1'b1) && (per_est_ff + 1'b1 >= $past(per_est_ff));
  endproperty
  a_smooth: assert property (p_smooth) else $error("abrupt period change");

  property p_edge_mark;
    $changed(core_ff) |-> edge_ff;
  endproperty
  a_edge_mark: assert property (p_edge_mark) else $error("core edge not marked");

  property p_half_cycle;
    edge_ff |-> (hc_cnt_ff == '0);
  endproperty
  a_half_cycle: assert property (p_half_cycle) else $error("half cycle counter not restarted");

  c_presc:  cover property (mode_ff == ccs_pkg::MODE_PRESC && edge_ff);
  c_direct: cover property (mode_ff == ccs_pkg::MODE_DIRECT && edge_ff);
  c_pll:    cover property (mode_ff == ccs_pkg::MODE_PLL && resync && edge_ff);
  c_reload: cover property (sw_reload && !long_hw_reset);

endmodule

`default_nettype wire

//--- core/ccs_pkg.sv
// Constants, types and helpers shared by the core clock mode selector
`default_nettype none

package ccs_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int PER_W         = 16;

  // ----------------------------------------------------------------
  // Reset configuration latch layout
  // ----------------------------------------------------------------
  localparam int             SEL_LSB        = 5;
  localparam int             SEL_MSB        = 7;
  localparam logic [7:0]     RCL_RESET      = 8'hFF;
  localparam int             RCR_UPPER_LSB  = 8;
  localparam int             RCR_UPPER_MSB  = 15;

  // ----------------------------------------------------------------
  // Selection codes and generation mechanisms
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SEL_X2P5   = 3'h0,
    SEL_DIV2   = 3'h1,
    SEL_X1P5   = 3'h2,
    SEL_DIRECT = 3'h3,
    SEL_X5     = 3'h4,
    SEL_X2     = 3'h5,
    SEL_X3     = 3'h6,
    SEL_X4     = 3'h7
  } ccs_sel_t;

  typedef enum logic [2:0] {
    MODE_PLL    = 3'b001,
    MODE_PRESC  = 3'b010,
    MODE_DIRECT = 3'b100
  } ccs_mode_t;

  // Twice the frequency factor, so half steps stay integer
  function automatic logic [3:0] ccs_twice_factor(input logic [2:0] sel);
    logic [3:0] f2;
    f2 = 4'h8;
    case (sel)
      SEL_X4:     f2 = 4'h8;
      SEL_X3:     f2 = 4'h6;
      SEL_X2:     f2 = 4'h4;
      SEL_X5:     f2 = 4'hA;
      SEL_DIRECT: f2 = 4'h2;
      SEL_X1P5:   f2 = 4'h3;
      SEL_DIV2:   f2 = 4'h1;
      SEL_X2P5:   f2 = 4'h5;
      default:    f2 = 4'h8;
    endcase
    return f2;
  endfunction

  // Mechanism that a selection code asks for
  function automatic ccs_mode_t ccs_decode_mode(input logic [2:0] sel);
    ccs_mode_t m;
    m = MODE_PLL;
    if (sel == SEL_DIRECT) begin
      m = MODE_DIRECT;
    end else if (sel == SEL_DIV2) begin
      m = MODE_PRESC;
    end
    return m;
  endfunction

  // Oscillator transitions between two resynchronisations (factor rounded up)
  function automatic logic [3:0] ccs_resync_count(input logic [2:0] sel);
    logic [4:0] t;
    t = {1'b0, ccs_twice_factor(sel)} + 5'h01;
    return t[4:1];
  endfunction

endpackage

`default_nettype wire

//--- core/ccs_osc_meter.sv
// Oscillator edge detector and period meter
`default_nettype none

module ccs_osc_meter (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // Oscillator input
  input  wire logic                     oscillator_clock,
  // Measurements
  output logic                          osc_level_ff,
  output logic                          osc_rise_ff,
  output logic                          osc_fall_ff,
  output logic [ccs_pkg::PER_W-1:0]     osc_period_ff
);

  logic [ccs_pkg::PER_W-1:0] cnt_ff;
  logic [ccs_pkg::PER_W-1:0] nxt_cnt;
  logic [ccs_pkg::PER_W-1:0] nxt_period;
  logic                      nxt_rise;
  logic                      nxt_fall;

  always_comb begin
    nxt_rise   = oscillator_clock & ~osc_level_ff;
    nxt_fall   = ~oscillator_clock & osc_level_ff;
    nxt_period = osc_period_ff;
    nxt_cnt    = (&cnt_ff) ? cnt_ff : cnt_ff + 1'b1;
    if (nxt_rise) begin
      nxt_period = nxt_cnt;
      nxt_cnt    = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      osc_level_ff  <= 1'b0;
      osc_rise_ff   <= 1'b0;
      osc_fall_ff   <= 1'b0;
      osc_period_ff <= '0;
      cnt_ff        <= '0;
    end else begin
      osc_level_ff  <= oscillator_clock;
      osc_rise_ff   <= nxt_rise;
      osc_fall_ff   <= nxt_fall;
      osc_period_ff <= nxt_period;
      cnt_ff        <= nxt_cnt;
    end
  end

endmodule

`default_nettype wire

//--- testbench/ccs_osc_model.sv
// Oscillator and reset-time configuration pin model
`default_nettype none

module ccs_osc_model (
  // Clock
  input  wire logic        clk,
  // Bench control
  input  wire logic [15:0] osc_half,
  input  wire logic        pin_hold,
  input  wire logic [7:0]  pins_want,
  // Device pins
  output var logic         oscillator_clock,
  output logic [7:0]       port0_upper_pins
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] cnt_ff = 16'h0000;
  logic        osc_ff = 1'b0;

  // Free-running oscillator, half period in clk cycles
  always @(posedge clk) begin
    if (cnt_ff + 16'h0001 >= osc_half) begin
      cnt_ff <= 16'h0000;
      osc_ff <= ~osc_ff;
    end else begin
      cnt_ff <= cnt_ff + 16'h0001;
    end
  end

  assign oscillator_clock = osc_ff;

  // Pins held during load
  // Released pins show the inverse so a stray load is seen
  assign port0_upper_pins = pin_hold ? pins_want : ~pins_want;
endmodule

`default_nettype wire

//--- testbench/cpu_clock_mode_select_bench.sv
// Self-checking bench for the core clock mode selector
`default_nettype none

module cpu_clock_mode_select_bench;
  timeunit 1ns;
  timeprecision 1ns;

  // ------------------------------------------------------------
  // Signals and instances
  // ------------------------------------------------------------
  typedef struct packed {logic [2:0] sel; logic pll; logic [15:0] half;} ccs_row_t;
  logic        clk;
  logic        rst_n;
  logic        long_hw_reset;
  logic [15:0] reset_control_reg;
  logic        sw_reload;
  logic [15:0] osc_half;
  logic        pin_hold;
  logic [7:0]  pins_want;
  logic        oscillator_clock;
  logic [7:0]  port0_upper_pins;
  logic [7:0]  reset_config_latch;
  logic [2:0]  clock_gen_select;
  logic        pll_enable;
  logic        core_clock;
  logic        core_edge;
  logic [15:0] half_cycle_time;
  logic        prev_core;
  logic [15:0] prev_half;
  logic        have;
  ccs_row_t    rows [8];
  int          fails;
  int          check_count;
  int          edge_cnt;
  int          edge_base;
  int          cycles;
  int          n;

  ccs_osc_model i_ccs_osc_model (.clk(clk), .osc_half(osc_half), .pin_hold(pin_hold), .pins_want(pins_want),
    .oscillator_clock(oscillator_clock), .port0_upper_pins(port0_upper_pins));

  ccs_clock_mode_select i_ccs_clock_mode_select (.clk(clk), .rst_n(rst_n), .oscillator_clock(oscillator_clock),
    .long_hw_reset(long_hw_reset), .port0_upper_pins(port0_upper_pins), .reset_control_reg(reset_control_reg),
    .sw_reload(sw_reload), .reset_config_latch(reset_config_latch), .clock_gen_select(clock_gen_select),
    .pll_enable(pll_enable), .core_clock(core_clock), .core_edge(core_edge), .half_cycle_time(half_cycle_time));

  // ------------------------------------------------------------
  // Tasks and monitors
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic reset_check();
    @(negedge clk);
    chk(16'(reset_config_latch), 16'(ccs_pkg::RCL_RESET));
    chk(16'(clock_gen_select), 16'(ccs_pkg::SEL_X4));
    chk(16'(pll_enable), 16'h0001);
    chk(16'(core_clock), 16'h0000);
    chk(16'(core_edge), 16'h0000);
    chk(half_cycle_time, 16'h0000);
    $display("test reset done");
  endtask

  task automatic load_pins(input logic [2:0] sel);
    @(posedge clk);
    pins_want <= {sel, 5'h0A};
    pin_hold <= 1'b1;
    long_hw_reset <= 1'b1;
    repeat (2) @(posedge clk);
    pin_hold <= 1'b0;
    long_hw_reset <= 1'b0;
    @(negedge clk);
    chk(16'(reset_config_latch), 16'({sel, 5'h0A}));
    chk(16'(clock_gen_select), 16'(sel));
  endtask

  initial begin
    clk = 1'b0;
    forever #(ccs_pkg::CLK_PERIOD_NS / 2) clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles >= 60000) begin
      fails++;
      summarize();
    end
  end

  always @(negedge clk) begin
    if (rst_n === 1'b1) begin
      chk(16'(core_edge), 16'(core_clock !== prev_core));
      if (core_edge === 1'b1) edge_cnt++;
    end
    prev_core = core_clock;
  end

  initial begin
    rst_n = 1'b0;
    long_hw_reset = 1'b0;
    reset_control_reg = 16'h0000;
    sw_reload = 1'b0;
    osc_half = 16'h003C;
    pin_hold = 1'b0;
    pins_want = 8'hFF;
    rows = '{'{3'h0, 1'b1, 16'h0018}, '{3'h1, 1'b0, 16'h0078}, '{3'h2, 1'b1, 16'h0028}, '{3'h3, 1'b0, 16'h003C},
             '{3'h4, 1'b1, 16'h000C}, '{3'h5, 1'b1, 16'h001E}, '{3'h6, 1'b1, 16'h0014}, '{3'h7, 1'b1, 16'h000F}};
    repeat (15) @(posedge clk);
    reset_check();
    @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      load_pins(rows[i].sel);
      @(negedge clk);
      chk(16'(pll_enable), 16'(rows[i].pll));
      repeat (2000) @(posedge clk);
      edge_base = edge_cnt;
      repeat (1200) @(posedge clk);
      @(negedge clk);
      n = 1200 / int'(rows[i].half);
      chk(half_cycle_time, rows[i].half);
      chk(16'(edge_cnt - edge_base >= n - 1 && edge_cnt - edge_base <= n + 1), 16'h0001);
      chk(16'(reset_config_latch), 16'({rows[i].sel, 5'h0A}));
      $display("test mode %0d done", i);
    end
    @(posedge clk);
    reset_control_reg <= 16'h3C55;
    sw_reload <= 1'b1;
    @(posedge clk);
    reset_control_reg <= 16'hA7AA;
    @(negedge clk);
    chk(16'(reset_config_latch), 16'h003C);
    @(posedge clk);
    pins_want <= 8'h61;
    pin_hold <= 1'b1;
    long_hw_reset <= 1'b1;
    @(negedge clk);
    chk(16'(reset_config_latch), 16'h00A7);
    @(posedge clk);
    long_hw_reset <= 1'b0;
    pin_hold <= 1'b0;
    sw_reload <= 1'b0;
    @(negedge clk);
    chk(16'(reset_config_latch), 16'h0061);
    chk(16'(clock_gen_select), 16'(ccs_pkg::SEL_DIRECT));
    $display("test reload done");
    load_pins(3'h7);
    repeat (2000) @(posedge clk);
    osc_half <= 16'h003E;
    have = 1'b0;
    repeat (4000) begin
      @(negedge clk);
      if (core_edge === 1'b1) begin
        if (have) chk(16'(half_cycle_time <= prev_half + 1 && prev_half <= half_cycle_time + 1), 16'h0001);
        prev_half = half_cycle_time;
        have = 1'b1;
      end
    end
    chk(16'(half_cycle_time == 16'h000F || half_cycle_time == 16'h0010), 16'h0001);
    $display("test resync done");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_check();
    @(posedge clk);
    rst_n <= 1'b1;
    // First two edges out of reset keep the reset state
    repeat (2) begin
      @(negedge clk);
      chk(16'(reset_config_latch), 16'(ccs_pkg::RCL_RESET));
      chk(16'(core_clock), 16'h0000);
      chk(16'(pll_enable), 16'h0001);
    end
    $display("test restart done");
    summarize();
  end
endmodule

`default_nettype wire
